// file: hdl/rtc_timekeeper.sv
// Real-time clock core: serial registers, alarms, wave output, reset recovery
// What this block does
// - With interrupt_or_wave_select at 0 the shared output carries a square wave at the selected rate.
// - With interrupt_or_wave_select at 1 the shared output goes low while an enabled alarm has matched.
// - After reset interrupt_or_wave_select is 1 and both alarms are disabled.
// - The reference output is held low if either of its two enable bits is 0.
// - After supply recovery with the oscillator running, the reset output stays asserted for the recovery delay.
// - With oscillator_disable at 1 the recovery delay is skipped and the reset output released at once.
// - The oscillator halted flag is set by reset and after the oscillator has been still for the stop-detection period.
// - The date rolls over at the end of short months, with the leap-year rule for February.
// - Hours count in a 24-hour format or a 12-hour format with an AM/PM bit.
// - Seconds, minutes, hours, day-of-week, date, month and year are kept and readable.
// - The oscillator frequency is offered on the reference output pin.
// - All registers are reached only through the two-wire serial interface.
module rtc_timekeeper #(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter longint unsigned REC_CYCLES = rtc_pkg::REC_CYCLES,
  parameter longint unsigned OSF_CYCLES = rtc_pkg::OSF_CYCLES,
  parameter longint unsigned IF_CYCLES = rtc_pkg::IF_CYCLES,
  parameter int unsigned OSC_PER_SEC = rtc_pkg::OSC_PER_SEC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Pins from outside
  input wire logic i_osc_32k,
  input wire logic i_vcc_good,
  // Serial interface
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Shared alarm or wave output, open drain
  output logic o_alarm_or_wave,
  output logic o_alarm_or_wave_oe,
  // Reference output
  output logic o_ref_32k,
  // Reset output, open drain
  output logic o_sys_rst_b,
  output logic o_sys_rst_oe
);

  rtc_cal_if cal ();

  logic [2:0] scl_s, sda_s;
  logic [1:0] osc_s, vcc_s;
  logic osc_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  rtc_pkg::rtc_state_e state_r;
  logic [3:0] bit_cnt_r, ptr_r;
  logic [7:0] shift_r, rd_byte;
  logic rw_r, first_r, sda_oe_r, wr_en_r;
  logic [3:0] wr_idx_r;
  logic [7:0] wr_data_r;
  logic [31:0] if_cnt_r, osf_cnt_r, rec_cnt_r;
  logic [7:0] ctl_r, sts_r;
  logic [7:0] alm_r [rtc_pkg::REG_A1_SEC:rtc_pkg::REG_A2_DATE];
  logic [14:0] div_r;
  logic tick_r, tick_d_r, wave_bit, osc_tick, a1_hit, a2_hit;
  logic wave_oe_r, ref_r, rst_oe_r;

  rtc_calendar rtc_calendar_inst (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .cal(cal)
  );

  assign cal.tick = tick_r;
  assign cal.wr_en = wr_en_r;
  assign cal.wr_idx = wr_idx_r;
  assign cal.wr_data = wr_data_r;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      osc_s <= 2'h0;
      osc_d <= 1'b0;
      vcc_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], i_scl};
      sda_s <= {sda_s[1:0], i_sda};
      osc_s <= {osc_s[0], i_osc_32k};
      osc_d <= osc_s[1];
      vcc_s <= {vcc_s[0], i_vcc_good};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign bus_stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign osc_tick = osc_s[1] & ~osc_d & ~ctl_r[rtc_pkg::CTL_OSC_DIS];

  // ==========================================================
  // Register read mux
  always_comb begin
    unique case (ptr_r)
      rtc_pkg::REG_SEC: rd_byte = cal.sec;
      rtc_pkg::REG_MIN: rd_byte = cal.min;
      rtc_pkg::REG_HOUR: rd_byte = cal.hour;
      rtc_pkg::REG_DOW: rd_byte = cal.dow;
      rtc_pkg::REG_DATE: rd_byte = cal.date;
      rtc_pkg::REG_MON: rd_byte = cal.mon;
      rtc_pkg::REG_YEAR: rd_byte = cal.year;
      rtc_pkg::REG_CONTROL: rd_byte = ctl_r;
      rtc_pkg::REG_STATUS: rd_byte = sts_r;
      default: rd_byte = alm_r[ptr_r];
    endcase
  end

  // ==========================================================
  // Serial slave engine
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= rtc_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      ptr_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_idx_r <= 4'h0;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= 1'b0;
      if (bus_start) begin
        state_r <= rtc_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (bus_stop || if_cnt_r >= 32'(IF_CYCLES)) begin
        state_r <= rtc_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (state_r)
          rtc_pkg::ST_IDLE: ;
          rtc_pkg::ST_ADDR, rtc_pkg::ST_WRITE: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s[1]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              if (state_r == rtc_pkg::ST_ADDR) begin
                if (shift_r[7:1] == DEV_ADDR) begin
                  rw_r <= shift_r[0];
                  first_r <= 1'b1;
                  sda_oe_r <= 1'b1;
                  state_r <= rtc_pkg::ST_ACK_ADDR;
                end else begin
                  state_r <= rtc_pkg::ST_IDLE;
                end
              end else begin
                if (first_r) begin
                  ptr_r <= shift_r[3:0];
                end else begin
                  wr_en_r <= 1'b1;
                  wr_idx_r <= ptr_r;
                  wr_data_r <= shift_r;
                  ptr_r <= ptr_r + 4'h1;
                end
                first_r <= 1'b0;
                sda_oe_r <= 1'b1;
                state_r <= rtc_pkg::ST_ACK_WR;
              end
            end
          end
          rtc_pkg::ST_ACK_ADDR, rtc_pkg::ST_ACK_WR: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (state_r == rtc_pkg::ST_ACK_ADDR && rw_r) begin
                shift_r <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                state_r <= rtc_pkg::ST_READ;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= rtc_pkg::ST_WRITE;
              end
            end
          end
          rtc_pkg::ST_READ: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                state_r <= rtc_pkg::ST_ACK_RD;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe_r <= ~shift_r[6];
              end
            end
          end
          rtc_pkg::ST_ACK_RD: begin
            if (scl_rise) begin
              if (sda_s[1]) begin
                state_r <= rtc_pkg::ST_IDLE;
              end else begin
                ptr_r <= ptr_r + 4'h1;
              end
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              shift_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              state_r <= rtc_pkg::ST_READ;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Interface timeout
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      if_cnt_r <= 32'h0;
    end else if (state_r == rtc_pkg::ST_IDLE || scl_s[1]) begin
      if_cnt_r <= 32'h0;
    end else if (if_cnt_r < 32'(IF_CYCLES)) begin
      if_cnt_r <= if_cnt_r + 32'h1;
    end
  end

  // ==========================================================
  // Control, alarm and status registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_r <= rtc_pkg::CTL_RESET;
    end else if (wr_en_r && wr_idx_r == rtc_pkg::REG_CONTROL) begin
      ctl_r <= wr_data_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = rtc_pkg::REG_A1_SEC; i <= rtc_pkg::REG_A2_DATE; i++) begin
        alm_r[i] <= rtc_pkg::ALM_RESET;
      end
    end else if (wr_en_r && wr_idx_r >= rtc_pkg::REG_A1_SEC && wr_idx_r <= rtc_pkg::REG_A2_DATE) begin
      alm_r[wr_idx_r] <= wr_data_r;
    end
  end

  assign a1_hit = tick_d_r && cal.sec == alm_r[rtc_pkg::REG_A1_SEC]
    && cal.min == alm_r[rtc_pkg::REG_A1_MIN] && cal.hour == alm_r[rtc_pkg::REG_A1_HOUR]
    && cal.date == alm_r[rtc_pkg::REG_A1_DATE];
  assign a2_hit = tick_d_r && cal.sec == 8'h00 && cal.min == alm_r[rtc_pkg::REG_A2_MIN]
    && cal.hour == alm_r[rtc_pkg::REG_A2_HOUR] && cal.date == alm_r[rtc_pkg::REG_A2_DATE];

  // Flags clear on a written 0; a set in the same cycle wins
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sts_r <= rtc_pkg::STS_RESET;
    end else begin
      if (wr_en_r && wr_idx_r == rtc_pkg::REG_STATUS) begin
        sts_r[rtc_pkg::STS_REF_EN] <= wr_data_r[rtc_pkg::STS_REF_EN];
        sts_r[rtc_pkg::STS_BB_REF_EN] <= wr_data_r[rtc_pkg::STS_BB_REF_EN];
        sts_r[rtc_pkg::STS_A1F] <= (sts_r[rtc_pkg::STS_A1F] & wr_data_r[rtc_pkg::STS_A1F])
          | a1_hit;
        sts_r[rtc_pkg::STS_A2F] <= (sts_r[rtc_pkg::STS_A2F] & wr_data_r[rtc_pkg::STS_A2F])
          | a2_hit;
        sts_r[rtc_pkg::STS_OSF] <= (sts_r[rtc_pkg::STS_OSF] & wr_data_r[rtc_pkg::STS_OSF])
          | (osf_cnt_r == 32'(OSF_CYCLES));
      end else begin
        sts_r[rtc_pkg::STS_A1F] <= sts_r[rtc_pkg::STS_A1F] | a1_hit;
        sts_r[rtc_pkg::STS_A2F] <= sts_r[rtc_pkg::STS_A2F] | a2_hit;
        sts_r[rtc_pkg::STS_OSF] <= sts_r[rtc_pkg::STS_OSF]
          | (osf_cnt_r == 32'(OSF_CYCLES));
      end
    end
  end

  // ==========================================================
  // Oscillator divider and stop detection
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r <= 15'h0000;
      tick_r <= 1'b0;
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick_r;
      tick_r <= osc_tick && div_r == 15'(OSC_PER_SEC - 1);
      if (osc_tick) begin
        div_r <= (div_r == 15'(OSC_PER_SEC - 1)) ? 15'h0000 : div_r + 15'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osf_cnt_r <= 32'h0;
    end else if (osc_s[1] != osc_d) begin
      osf_cnt_r <= 32'h0;
    end else if (osf_cnt_r < 32'(OSF_CYCLES)) begin
      osf_cnt_r <= osf_cnt_r + 32'h1;
    end
  end

  // ==========================================================
  // Pin drivers
  always_comb begin
    unique case (ctl_r[rtc_pkg::CTL_RS_HI:rtc_pkg::CTL_RS_LO])
      2'h0: wave_bit = div_r >= 15'(OSC_PER_SEC / 2);
      2'h1: wave_bit = div_r[4];
      2'h2: wave_bit = div_r[2];
      2'h3: wave_bit = div_r[1];
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wave_oe_r <= 1'b0;
    end else if (ctl_r[rtc_pkg::CTL_INTERRUPT_OR_WAVE_SELECT]) begin
      wave_oe_r <= (sts_r[rtc_pkg::STS_A1F] & ctl_r[rtc_pkg::CTL_A1_EN])
        | (sts_r[rtc_pkg::STS_A2F] & ctl_r[rtc_pkg::CTL_A2_EN]);
    end else begin
      wave_oe_r <= ~wave_bit;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_r <= 1'b0;
    end else begin
      ref_r <= osc_s[1] & sts_r[rtc_pkg::STS_REF_EN]
        & sts_r[rtc_pkg::STS_BB_REF_EN];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_oe_r <= 1'b1;
      rec_cnt_r <= 32'h0;
    end else if (!vcc_s[1]) begin
      rst_oe_r <= 1'b1;
      rec_cnt_r <= 32'h0;
    end else if (ctl_r[rtc_pkg::CTL_OSC_DIS]) begin
      rst_oe_r <= 1'b0;
    end else if (rst_oe_r && osf_cnt_r < 32'(OSF_CYCLES)) begin
      rec_cnt_r <= rec_cnt_r + 32'h1;
      if (rec_cnt_r >= 32'(REC_CYCLES - 1)) begin
        rst_oe_r <= 1'b0;
      end
    end
  end

  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_r;
  assign o_alarm_or_wave = 1'b0;
  assign o_alarm_or_wave_oe = wave_oe_r;
  assign o_ref_32k = ref_r;
  assign o_sys_rst_b = 1'b0;
  assign o_sys_rst_oe = rst_oe_r;

endmodule : rtc_timekeeper

// file: hdl/rtc_pkg.sv
// Shared constants and types of the real-time clock core
package rtc_pkg;

  // ==========================================================
  // Register indices
  localparam logic [3:0] REG_SEC = 4'h0;
  localparam logic [3:0] REG_MIN = 4'h1;
  localparam logic [3:0] REG_HOUR = 4'h2;
  localparam logic [3:0] REG_DOW = 4'h3;
  localparam logic [3:0] REG_DATE = 4'h4;
  localparam logic [3:0] REG_MON = 4'h5;
  localparam logic [3:0] REG_YEAR = 4'h6;
  localparam logic [3:0] REG_A1_SEC = 4'h7;
  localparam logic [3:0] REG_A1_MIN = 4'h8;
  localparam logic [3:0] REG_A1_HOUR = 4'h9;
  localparam logic [3:0] REG_A1_DATE = 4'ha;
  localparam logic [3:0] REG_A2_MIN = 4'hb;
  localparam logic [3:0] REG_A2_HOUR = 4'hc;
  localparam logic [3:0] REG_A2_DATE = 4'hd;
  localparam logic [3:0] REG_CONTROL = 4'he;
  localparam logic [3:0] REG_STATUS = 4'hf;

  // ==========================================================
  // Field positions
  localparam int CTL_A1_EN = 0;
  localparam int CTL_A2_EN = 1;
  localparam int CTL_INTERRUPT_OR_WAVE_SELECT = 2;
  localparam int CTL_RS_LO = 3;
  localparam int CTL_RS_HI = 4;
  localparam int CTL_OSC_DIS = 7;
  localparam int STS_A1F = 0;
  localparam int STS_A2F = 1;
  localparam int STS_REF_EN = 3;
  localparam int STS_BB_REF_EN = 6;
  localparam int STS_OSF = 7;
  localparam int HOUR_12H = 6;
  localparam int HOUR_PM = 5;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] CTL_RESET = 8'h04;
  localparam logic [7:0] STS_RESET = 8'hc8;
  localparam logic [7:0] CAL_ZERO = 8'h00;
  localparam logic [7:0] CAL_ONE = 8'h01;
  localparam logic [7:0] ALM_RESET = 8'h00;

  // ==========================================================
  // Timing
  localparam longint unsigned CLK_HZ = 64'd25000000;
  localparam longint unsigned T_REC_MS = 64'd125;
  localparam longint unsigned T_OSF_MS = 64'd100;
  localparam longint unsigned T_IF_MS = 64'd25;
  localparam longint unsigned REC_CYCLES = T_REC_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned OSF_CYCLES = T_OSF_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned IF_CYCLES = T_IF_MS * CLK_HZ / 64'd1000;
  localparam int unsigned OSC_PER_SEC = 32768;

  // ==========================================================
  // Serial engine states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK_ADDR = 7'h04,
    ST_WRITE = 7'h08,
    ST_ACK_WR = 7'h10,
    ST_READ = 7'h20,
    ST_ACK_RD = 7'h40
  } rtc_state_e;

endpackage : rtc_pkg

// file: hdl/rtc_cal_if.sv
// Carrier between the register engine and the calendar counters
interface rtc_cal_if;
  logic tick;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] sec;
  logic [7:0] min;
  logic [7:0] hour;
  logic [7:0] dow;
  logic [7:0] date;
  logic [7:0] mon;
  logic [7:0] year;
  modport cal (input tick, wr_en, wr_idx, wr_data,
               output sec, min, hour, dow, date, mon, year);
  modport ctl (output tick, wr_en, wr_idx, wr_data,
               input sec, min, hour, dow, date, mon, year);
endinterface : rtc_cal_if

// file: hdl/rtc_calendar.sv
// Seconds-to-year calendar counters
module rtc_calendar (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Calendar carrier
  rtc_cal_if.cal cal
);

  logic [7:0] sec_r, min_r, hour_r, dow_r, date_r, mon_r, year_r;
  logic [7:0] hour_nxt;
  logic day_roll;

  function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: days_in_month = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: days_in_month = 8'h1e;
      default: days_in_month = 8'h1f;
    endcase
  endfunction : days_in_month

  // ==========================================================
  // Hour step
  always_comb begin
    hour_nxt = hour_r;
    day_roll = 1'b0;
    if (hour_r[rtc_pkg::HOUR_12H]) begin
      if (hour_r[4:0] == 5'h0b) begin
        hour_nxt = {hour_r[7:6], ~hour_r[5], 5'h0c};
        day_roll = hour_r[rtc_pkg::HOUR_PM];
      end else if (hour_r[4:0] == 5'h0c) begin
        hour_nxt = {hour_r[7:5], 5'h01};
      end else begin
        hour_nxt = {hour_r[7:5], hour_r[4:0] + 5'h01};
      end
    end else if (hour_r[5:0] == 6'h17) begin
      hour_nxt = {hour_r[7:6], 6'h00};
      day_roll = 1'b1;
    end else begin
      hour_nxt = {hour_r[7:6], hour_r[5:0] + 6'h01};
    end
  end

  // ==========================================================
  // Counters
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sec_r <= rtc_pkg::CAL_ZERO;
      min_r <= rtc_pkg::CAL_ZERO;
      hour_r <= rtc_pkg::CAL_ZERO;
      dow_r <= rtc_pkg::CAL_ONE;
      date_r <= rtc_pkg::CAL_ONE;
      mon_r <= rtc_pkg::CAL_ONE;
      year_r <= rtc_pkg::CAL_ZERO;
    end else if (cal.wr_en) begin
      unique case (cal.wr_idx)
        rtc_pkg::REG_SEC: sec_r <= cal.wr_data;
        rtc_pkg::REG_MIN: min_r <= cal.wr_data;
        rtc_pkg::REG_HOUR: hour_r <= cal.wr_data;
        rtc_pkg::REG_DOW: dow_r <= cal.wr_data;
        rtc_pkg::REG_DATE: date_r <= cal.wr_data;
        rtc_pkg::REG_MON: mon_r <= cal.wr_data;
        rtc_pkg::REG_YEAR: year_r <= cal.wr_data;
        default: ;
      endcase
    end else if (cal.tick) begin
      sec_r <= (sec_r == 8'h3b) ? 8'h00 : sec_r + 8'h01;
      if (sec_r == 8'h3b) begin
        min_r <= (min_r == 8'h3b) ? 8'h00 : min_r + 8'h01;
        if (min_r == 8'h3b) begin
          hour_r <= hour_nxt;
          if (day_roll) begin
            dow_r <= (dow_r == 8'h07) ? 8'h01 : dow_r + 8'h01;
            if (date_r >= days_in_month(mon_r, year_r)) begin
              date_r <= 8'h01;
              mon_r <= (mon_r == 8'h0c) ? 8'h01 : mon_r + 8'h01;
              if (mon_r == 8'h0c) begin
                year_r <= (year_r == 8'h63) ? 8'h00 : year_r + 8'h01;
              end
            end else begin
              date_r <= date_r + 8'h01;
            end
          end
        end
      end
    end
  end

  assign cal.sec = sec_r;
  assign cal.min = min_r;
  assign cal.hour = hour_r;
  assign cal.dow = dow_r;
  assign cal.date = date_r;
  assign cal.mon = mon_r;
  assign cal.year = year_r;

endmodule : rtc_calendar

// file: bench/rtc_timekeeper_monitor.sv
// Pin checker of the timekeeping core
module rtc_timekeeper_monitor (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Watched pins
  input wire logic i_osc_32k,
  input wire logic i_vcc_good,
  input wire logic i_scl,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_alarm_or_wave,
  input wire logic o_ref_32k,
  input wire logic o_sys_rst_b,
  input wire logic o_sys_rst_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int good_cnt;
  logic [5:0] osc_h;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  // ==========
  // Supply-good age and oscillator history
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      good_cnt <= 0;
    end else if (!i_vcc_good) begin
      good_cnt <= 0;
    end else if (good_cnt < 1000) begin
      good_cnt <= good_cnt + 1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_h <= 6'h00;
    end else begin
      osc_h <= {osc_h[4:0], i_osc_32k};
    end
  end
  // ==========
  // Assertions
  sequence s_vcc_low;
    !i_vcc_good [*5];
  endsequence
  sequence s_osc_low;
    !i_osc_32k [*6];
  endsequence
  sequence s_ack_rise;
    $rose(o_sda_oe);
  endsequence
  a_const_zero: assert property (!o_sda && !o_alarm_or_wave && !o_sys_rst_b)
    else $error("open-drain value not low");
  a_vcc_low_rst: assert property (s_vcc_low |-> o_sys_rst_oe)
    else $error("reset output not asserted with supply low");
  a_rst_rise_vcc: assert property ($rose(o_sys_rst_oe) |-> !$past(i_vcc_good))
    else $error("reset output asserted with supply good");
  a_rec_min_wait: assert property ($fell(o_sys_rst_oe) |-> good_cnt >= 2)
    else $error("reset output released too early");
  a_ref_osc_lag: assert property (o_ref_32k |-> |osc_h)
    else $error("reference high without oscillator");
  a_ref_idle_low: assert property (s_osc_low |-> !o_ref_32k)
    else $error("reference high with oscillator low");
  a_sda_change_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 3))
    else $error("data line changed with clock high");
  a_ack_hold_min: assert property (s_ack_rise |=> o_sda_oe [*4])
    else $error("data pull too short");
endmodule : rtc_timekeeper_monitor
bind rtc_timekeeper rtc_timekeeper_monitor rtc_timekeeper_monitor_inst (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_osc_32k(i_osc_32k),
  .i_vcc_good(i_vcc_good), .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_alarm_or_wave(o_alarm_or_wave), .o_ref_32k(o_ref_32k),
  .o_sys_rst_b(o_sys_rst_b), .o_sys_rst_oe(o_sys_rst_oe)
);

// file: bench/rtc_i2c_host.sv
// Serial host model on the far side of the core
module rtc_i2c_host (
  // Clock and bus
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl = 1'b1,
  output logic sda,
  // Read results
  output logic rd_done = 1'b0,
  output logic [7:0] rd_byte = 8'h00,
  output logic nak_seen = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_h = 1'b1;
  logic ack_r = 1'b0;
  // Pull-up wins unless a party pulls low
  assign sda = sda_h & ~sda_oe;
  // Quarter bit, SCL never low near the timeout
  task automatic tq;
    repeat (2) @(posedge clk);
  endtask : tq
  task automatic bit_io(input logic b, output logic r);
    sda_h <= b;
    tq();
    scl <= 1'b1;
    tq();
    r = sda;
    tq();
    scl <= 1'b0;
    tq();
  endtask : bit_io
  task automatic start;
    sda_h <= 1'b1;
    tq();
    tq();
    scl <= 1'b1;
    tq();
    sda_h <= 1'b0;
    tq();
    scl <= 1'b0;
    tq();
  endtask : start
  task automatic stop;
    sda_h <= 1'b0;
    tq();
    scl <= 1'b1;
    tq();
    tq();
    sda_h <= 1'b1;
    tq();
  endtask : stop
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack_r = ~r;
    if (r !== 1'b0) nak_seen = 1'b1;
  endtask : tx
  // Pointer then auto-incremented data
  task automatic wr(input logic [3:0] p, input logic [7:0] d [11], input int n);
    start();
    tx(8'ha0);
    tx({4'h0, p});
    for (int i = 0; i < n; i++) tx(d[i]);
    stop();
  endtask : wr
  task automatic rd(input logic [3:0] p);
    logic [7:0] d;
    logic r;
    start();
    tx(8'ha0);
    tx({4'h0, p});
    start();
    tx(8'ha1);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
    rd_byte <= d;
    rd_done <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask : rd
endmodule : rtc_i2c_host

// file: bench/test_rtc_timekeeper.sv
// Self-checking bench of the timekeeping core
module test_rtc_timekeeper;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic osc = 1'b0;
  logic osc_run = 1'b1;
  logic vcc = 1'b0;
  logic scl, sda, sda_oe, aw_oe, ref32, rst_oe, rd_done, nak_seen, f;
  logic [7:0] rd_byte, y;
  logic [7:0] cal [11];
  logic [2:0] div = 3'h0;
  logic [7:0] exp_q [$];
  int err_count = 0;
  int n_checks = 0;
  int h;
  int eh [4] = '{128, 128, 32, 16};
  always #20 clk = ~clk;
  // Oscillator, period 8 core cycles
  always @(posedge clk) begin
    div <= div + 3'h1;
    if (osc_run && div[1:0] == 2'h3) begin
      osc <= ~osc;
    end
  end
  rtc_timekeeper #(.REC_CYCLES(200), .OSF_CYCLES(1000), .IF_CYCLES(500), .OSC_PER_SEC(32))
    rtc_timekeeper_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_osc_32k(osc),
    .i_vcc_good(vcc), .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe),
    .o_alarm_or_wave(), .o_alarm_or_wave_oe(aw_oe), .o_ref_32k(ref32),
    .o_sys_rst_b(), .o_sys_rst_oe(rst_oe));
  rtc_i2c_host rtc_i2c_host_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .rd_done(rd_done), .rd_byte(rd_byte), .nak_seen(nak_seen));
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: pin %b expected %b", $time, g, e);
    end
  endtask : chk_bit
  // Read results checked as they appear
  always @(posedge clk) begin
    if (rd_done === 1'b1) chk_byte(exp_q.pop_front(), rd_byte);
  end
  task automatic w1(input logic [3:0] p, input logic [7:0] v);
    logic [7:0] d [11];
    d[0] = v;
    rtc_i2c_host_inst.wr(p, d, 1);
  endtask : w1
  task automatic rc(input logic [3:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    rtc_i2c_host_inst.rd(p);
  endtask : rc
  task automatic act(output logic r);
    r = 1'b0;
    repeat (40) @(posedge clk) r |= ref32;
  endtask : act
  task automatic meas(output int n);
    logic v;
    v = aw_oe;
    for (n = 0; aw_oe === v && n < 4000; n++) @(posedge clk);
    v = aw_oe;
    for (n = 0; aw_oe === v && n < 4000; n++) @(posedge clk);
  endtask : meas
  task automatic final_report;
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    err_count++;
    final_report();
  end
  initial begin
    void'($urandom(62864));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    chk_bit(1'b1, rst_oe);
    vcc <= 1'b1;
    repeat (100) @(posedge clk);
    chk_bit(1'b1, rst_oe);
    repeat (150) @(posedge clk);
    chk_bit(1'b0, rst_oe);
    chk_bit(1'b0, aw_oe);
    rc(4'he, 8'h04);
    rc(4'hf, 8'hc8);
    act(f);
    chk_bit(1'b1, f);
    w1(4'hf, 8'h40);
    act(f);
    chk_bit(1'b0, f);
    w1(4'hf, 8'h08);
    act(f);
    chk_bit(1'b0, f);
    w1(4'hf, 8'h48);
    act(f);
    chk_bit(1'b1, f);
    osc_run <= 1'b0;
    rc(4'hf, 8'h48);
    repeat (1000) @(posedge clk);
    rc(4'hf, 8'hc8);
    osc_run <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      w1(4'he, {3'h0, 2'(s), 3'h0});
      meas(h);
      chk_bit(1'b1, h > eh[s] - 3 && h < eh[s] + 3);
    end
    y = 8'($urandom_range(99));
    w1(4'h6, y);
    rc(4'h6, y);
    w1(4'h2, 8'h6b);
    rc(4'h2, 8'h6b);
    for (int k = 0; k < 2; k++) begin
      w1(4'he, 8'h84);
      cal = '{8'h3b, 8'h3b, 8'h17, 8'h01, 8'h1c, 8'h02, 8'(3 + k), 8'h03, 8'h00, 8'h00, 8'h1d};
      rtc_i2c_host_inst.wr(4'h0, cal, 11);
      w1(4'he, 8'h05);
      repeat (400) @(posedge clk);
      rc(4'h4, k ? 8'h1d : 8'h01);
      rc(4'h5, k ? 8'h02 : 8'h03);
      rc(4'h2, 8'h00);
    end
    chk_bit(1'b1, aw_oe);
    w1(4'he, 8'h04);
    chk_bit(1'b0, aw_oe);
    w1(4'he, 8'h84);
    vcc <= 1'b0;
    repeat (10) @(posedge clk);
    chk_bit(1'b1, rst_oe);
    vcc <= 1'b1;
    repeat (10) @(posedge clk);
    chk_bit(1'b0, rst_oe);
    chk_bit(1'b0, nak_seen);
    rtc_i2c_host_inst.start();
    rtc_i2c_host_inst.tx(8'h42);
    rtc_i2c_host_inst.stop();
    chk_bit(1'b0, rtc_i2c_host_inst.ack_r);
    repeat (20) @(posedge clk);
    final_report();
  end
endmodule : test_rtc_timekeeper
